/* rtl/ssa_regs_cfg.svh */
`ifndef SSA_REGS_CFG_SVH
`define SSA_REGS_CFG_SVH
`define PC_RX_RESET 0
`define PC_TX_RESET 1
`define PC_STRIP_SYNC 2
`define PC_CLEAR_SYNC 3
`define PC_TX_IRQ_EN 4
`define PC_RX_IRQ_EN 5
`define PC_ADDR_LO 6
`define PC_ADDR_HI 7
`define PC_RESET_VAL 8'h03
`define SC_RESET_VAL 8'h00
`define TC_RESET_VAL 4'h0
`define SP_RESET_VAL 8'h00
`define TC_EXT_SYNC 0
`define TC_TWO_SYNC 1
`define TC_CLR_CTS 2
`define TC_CLR_UNDERFLOW 3
`define ST_RX_AVAIL 0
`define ST_TX_AVAIL 1
`define ST_DCD 2
`define ST_CTS 3
`define ST_UNDERFLOW 4
`define ST_OVERRUN 5
`define ST_PARITY 6
`define ST_IRQ 7
`define TX_RELOAD_CYCLES 1
`endif

/* rtl/ssa_regs_pkg.sv */
package ssa_regs_pkg;
  typedef enum logic [1:0] {
    SEL_SECONDARY,
    SEL_TERTIARY,
    SEL_SYNC,
    SEL_TX_FIFO
  } write_sel_t;
  typedef enum {
    TX_HELD,
    TX_SETTLE,
    TX_READY
  } tx_state_t;
endpackage

/* rtl/ssa_regs.sv */
`timescale 1ns/100ps
`include "ssa_regs_cfg.svh"
module ssa_regs import ssa_regs_pkg::*; #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Processor bus
  input wire logic chip_select_n_in,
  input wire logic register_select_line_in,
  input wire logic read_not_write_in,
  input wire logic [WIDTH-1:0] data_in,
  output logic [WIDTH-1:0] data_out,
  output logic data_oe_out,
  // Receive side
  input wire logic rx_char_valid_in,
  input wire logic [WIDTH-1:0] rx_char_in,
  input wire logic rx_sync_char_in,
  input wire logic rx_shift_bit_in,
  input wire logic rx_parity_err_in,
  input wire logic dcd_event_in,
  input wire logic [WIDTH-1:0] rx_fifo_data_in,
  input wire logic rx_fifo_avail_in,
  input wire logic rx_overrun_in,
  output logic rx_fifo_push_out,
  output logic [WIDTH-1:0] rx_fifo_wdata_out,
  output logic rx_fifo_pop_out,
  output logic [WIDTH-1:0] rx_shift_out,
  output logic rx_reset_out,
  // Transmit side
  input wire logic tx_fifo_space_in,
  input wire logic tx_underflow_in,
  input wire logic cts_event_in,
  input wire logic cts_level_in,
  output logic tx_fifo_push_out,
  output logic [WIDTH-1:0] tx_fifo_wdata_out,
  output logic tx_reset_out,
  // Control outputs
  output logic [WIDTH-1:0] primary_control_out,
  output logic [WIDTH-1:0] secondary_control_out,
  output logic [3:0] tertiary_control_out,
  output logic [WIDTH-1:0] sync_pattern_out
);

  logic [WIDTH-1:0] primary_control_q, primary_control_d;
  logic [WIDTH-1:0] secondary_control_q, secondary_control_d;
  logic [3:0] tertiary_control_q, tertiary_control_d;
  logic [WIDTH-1:0] sync_pattern_q, sync_pattern_d;
  logic [WIDTH-1:0] rx_shift_q, rx_shift_d;
  logic parity_q, parity_d;
  logic dcd_q, dcd_d;
  logic underflow_q, underflow_d;
  logic cts_q, cts_d;
  logic rx_push_q, rx_push_d;
  logic [WIDTH-1:0] rx_data_q, rx_data_d;
  logic tx_push_q, tx_push_d;
  logic [WIDTH-1:0] tx_data_q, tx_data_d;
  logic [WIDTH-1:0] rd_q, rd_d;
  logic rd_oe_q, rd_oe_d;
  logic rx_pop_q, rx_pop_d;
  tx_state_t tx_state_q, tx_state_d;
  logic [3:0] reload_cnt_q, reload_cnt_d;
  logic wr_cycle, rd_cycle, rx_rst, tx_rst, tx_avail;
  logic rx_avail, irq_now;
  write_sel_t wsel;

  // Write with select high aimed at one target
  function automatic logic sel_write(input logic wr, input logic rs, input write_sel_t sel,
                                     input write_sel_t target);
    return wr && rs && (sel == target);
  endfunction

  // Level that only counts while its section runs
  function automatic logic run_gate(input logic level, input logic held);
    return level && !held;
  endfunction

  // Status byte as the processor sees it
  function automatic logic [7:0] status_byte(input logic rx_av, input logic tx_av, input logic dcd,
                                             input logic cts, input logic uf, input logic ovr,
                                             input logic par, input logic irq);
    logic [7:0] s;
    s = 8'h00;
    s[`ST_RX_AVAIL] = rx_av;
    s[`ST_TX_AVAIL] = tx_av;
    s[`ST_DCD] = dcd;
    s[`ST_CTS] = cts;
    s[`ST_UNDERFLOW] = uf;
    s[`ST_OVERRUN] = ovr;
    s[`ST_PARITY] = par;
    s[`ST_IRQ] = irq;
    return s;
  endfunction

  // Bus decode and derived levels
  always_comb begin
    wr_cycle = !chip_select_n_in && !read_not_write_in;
    rd_cycle = !chip_select_n_in && read_not_write_in;
    wsel = write_sel_t'({primary_control_q[`PC_ADDR_HI], primary_control_q[`PC_ADDR_LO]});
    rx_rst = primary_control_q[`PC_RX_RESET];
    tx_rst = primary_control_q[`PC_TX_RESET];
    rx_avail = run_gate(rx_fifo_avail_in, rx_rst);
    // Availability held off while in reset
    tx_avail = run_gate(tx_fifo_space_in && (tx_state_q == TX_READY), tx_rst);
    irq_now = dcd_q || cts_q || (primary_control_q[`PC_TX_IRQ_EN] && tx_avail) ||
              (primary_control_q[`PC_RX_IRQ_EN] && rx_avail);
  end

  // Register writes and transmit loads
  always_comb begin
    primary_control_d = primary_control_q;
    secondary_control_d = secondary_control_q;
    tertiary_control_d = tertiary_control_q;
    sync_pattern_d = sync_pattern_q;
    tx_push_d = 1'b0;
    tx_data_d = tx_data_q;
    if (wr_cycle && !register_select_line_in) begin
      primary_control_d = data_in;
    end
    if (wr_cycle && register_select_line_in) begin
      case (wsel)
        SEL_SECONDARY: secondary_control_d = data_in;
        SEL_TERTIARY: tertiary_control_d = data_in[3:0];
        SEL_SYNC: sync_pattern_d = data_in;
        SEL_TX_FIFO: begin
          if (tx_state_q == TX_READY && !tx_rst) begin
            tx_push_d = 1'b1;
            tx_data_d = data_in;
          end
        end
        default: secondary_control_d = secondary_control_q;
      endcase
    end
    // Transmit path cleared while held
    if (tx_rst) begin
      tx_push_d = 1'b0;
      tx_data_d = '0;
    end
  end

  // Transmit reload timing
  always_comb begin
    tx_state_d = tx_state_q;
    reload_cnt_d = reload_cnt_q;
    case (tx_state_q)
      TX_HELD: begin
        if (!primary_control_d[`PC_TX_RESET]) begin
          tx_state_d = TX_SETTLE;
          reload_cnt_d = 4'(`TX_RELOAD_CYCLES);
        end
      end
      TX_SETTLE: begin
        if (tx_rst) begin
          tx_state_d = TX_HELD;
        end else if (reload_cnt_q <= 4'h1) begin
          tx_state_d = TX_READY;
        end else begin
          reload_cnt_d = reload_cnt_q - 4'h1;
        end
      end
      TX_READY: begin
        if (tx_rst) begin
          tx_state_d = TX_HELD;
        end
      end
      default: tx_state_d = TX_HELD;
    endcase
  end

  // Receive path and sticky flags
  always_comb begin
    rx_shift_d = rx_shift_q;
    rx_push_d = 1'b0;
    rx_data_d = rx_data_q;
    parity_d = parity_q | rx_parity_err_in;
    dcd_d = dcd_q | dcd_event_in;
    underflow_d = underflow_q;
    cts_d = cts_q;
    if (rx_char_valid_in) begin
      rx_shift_d = {rx_shift_q[WIDTH-2:0], rx_shift_bit_in};
    end
    if (rx_char_valid_in && !rx_sync_char_in) begin
      if (!(primary_control_q[`PC_STRIP_SYNC] && rx_char_in == sync_pattern_q)) begin
        rx_push_d = 1'b1;
        rx_data_d = rx_char_in;
      end
    end
    if (rx_rst) begin
      rx_shift_d = '1;
      rx_push_d = 1'b0;
      parity_d = 1'b0;
      dcd_d = 1'b0;
    end
    // Set wins over software clear
    if (sel_write(wr_cycle, register_select_line_in, wsel, SEL_TERTIARY)) begin
      if (data_in[`TC_CLR_UNDERFLOW]) underflow_d = 1'b0;
      if (data_in[`TC_CLR_CTS]) cts_d = 1'b0;
    end
    if (tx_underflow_in) underflow_d = 1'b1;
    if (cts_event_in) cts_d = 1'b1;
    if (tx_rst) begin
      underflow_d = 1'b0;
      cts_d = 1'b0;
    end
  end

  // Read port
  always_comb begin
    rd_d = '0;
    rd_oe_d = rd_cycle;
    rx_pop_d = 1'b0;
    if (rd_cycle && !register_select_line_in) begin
      rd_d = WIDTH'(status_byte(rx_avail, tx_avail, dcd_q, cts_level_in, underflow_q, rx_overrun_in,
                                parity_q, irq_now));
    end else if (rd_cycle) begin
      rd_d = rx_fifo_data_in;
      rx_pop_d = !rx_rst;
    end
  end

  // Register and load state
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      primary_control_q <= `PC_RESET_VAL;
      secondary_control_q <= `SC_RESET_VAL;
      tertiary_control_q <= `TC_RESET_VAL;
      sync_pattern_q <= `SP_RESET_VAL;
      tx_push_q <= 1'b0;
      tx_data_q <= '0;
    end else begin
      primary_control_q <= primary_control_d;
      secondary_control_q <= secondary_control_d;
      tertiary_control_q <= tertiary_control_d;
      sync_pattern_q <= sync_pattern_d;
      tx_push_q <= tx_push_d;
      tx_data_q <= tx_data_d;
    end
  end

  // Reload timing state
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      tx_state_q <= TX_HELD;
      reload_cnt_q <= 4'h0;
    end else begin
      tx_state_q <= tx_state_d;
      reload_cnt_q <= reload_cnt_d;
    end
  end

  // Receive and flag state
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rx_shift_q <= '1;
      parity_q <= 1'b0;
      dcd_q <= 1'b0;
      underflow_q <= 1'b0;
      cts_q <= 1'b0;
      rx_push_q <= 1'b0;
      rx_data_q <= '0;
    end else begin
      rx_shift_q <= rx_shift_d;
      parity_q <= parity_d;
      dcd_q <= dcd_d;
      underflow_q <= underflow_d;
      cts_q <= cts_d;
      rx_push_q <= rx_push_d;
      rx_data_q <= rx_data_d;
    end
  end

  // Read port state
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rd_q <= '0;
      rd_oe_q <= 1'b0;
      rx_pop_q <= 1'b0;
    end else begin
      rd_q <= rd_d;
      rd_oe_q <= rd_oe_d;
      rx_pop_q <= rx_pop_d;
    end
  end

  // Outputs straight from registers
  always_comb begin
    data_out = rd_q;
    data_oe_out = rd_oe_q;
    rx_fifo_push_out = rx_push_q;
    rx_fifo_wdata_out = rx_data_q;
    rx_fifo_pop_out = rx_pop_q;
    rx_shift_out = rx_shift_q;
    rx_reset_out = rx_rst;
    tx_fifo_push_out = tx_push_q;
    tx_fifo_wdata_out = tx_data_q;
    tx_reset_out = tx_rst;
    primary_control_out = primary_control_q;
    secondary_control_out = secondary_control_q;
    tertiary_control_out = tertiary_control_q;
    sync_pattern_out = sync_pattern_q;
  end

endmodule // ssa_regs

/* verification/ssa_regs_assertions.sv */
`timescale 1ns/100ps
module ssa_regs_chk (
  // Bus side
  input logic clk_in, rst_in, chip_select_n_in, register_select_line_in, read_not_write_in,
  input logic [7:0] data_in, data_out, primary_control_out, sync_pattern_out,
  // Data side
  input logic rx_char_valid_in, rx_sync_char_in, rx_fifo_push_out, rx_reset_out, tx_fifo_push_out, tx_reset_out,
  input logic [7:0] rx_char_in, rx_shift_out
);
  wire wr = !chip_select_n_in && !read_not_write_in;
  wire rs = register_select_line_in;
  wire rxc = rx_char_valid_in && !rx_sync_char_in && !rx_reset_out;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  sequence s_tx_ready; !tx_reset_out ##1 !tx_reset_out; endsequence
  property p_pc; wr && !rs |=> primary_control_out == $past(data_in); endproperty
  a_pc: assert property (p_pc) else $error("pc write lost");
  property p_sync; wr && rs && primary_control_out[7:6] == 2'h2 |=> sync_pattern_out == $past(data_in); endproperty
  a_sync: assert property (p_sync) else $error("sync write lost");
  property p_ones; rx_reset_out && $past(rx_reset_out) |-> rx_shift_out == 8'hFF; endproperty
  a_ones: assert property (p_ones) else $error("shifter not ones");
  property p_hold; wr && rs && tx_reset_out |=> !tx_fifo_push_out; endproperty
  a_hold: assert property (p_hold) else $error("push in reset");
  property p_load; s_tx_ready ##0 (wr && rs && primary_control_out[7:6] == 2'h3) |=> tx_fifo_push_out; endproperty
  a_load: assert property (p_load) else $error("push missing");
  property p_strip; rxc && primary_control_out[2] && rx_char_in == sync_pattern_out |=> !rx_fifo_push_out; endproperty
  a_strip: assert property (p_strip) else $error("sync kept");
  property p_drop; rx_char_valid_in && rx_sync_char_in |=> !rx_fifo_push_out; endproperty
  a_drop: assert property (p_drop) else $error("sync char kept");
  property p_avail; !chip_select_n_in && read_not_write_in && !rs && tx_reset_out |=> !data_out[1]; endproperty
  a_avail: assert property (p_avail) else $error("tx avail set");
endmodule // ssa_regs_chk
bind ssa_regs ssa_regs_chk ssa_regs_chk_i (
  .clk_in(clk_in),
  .rst_in(rst_in),
  .chip_select_n_in(chip_select_n_in),
  .register_select_line_in(register_select_line_in),
  .read_not_write_in(read_not_write_in),
  .data_in(data_in),
  .data_out(data_out),
  .primary_control_out(primary_control_out),
  .sync_pattern_out(sync_pattern_out),
  .rx_char_valid_in(rx_char_valid_in),
  .rx_sync_char_in(rx_sync_char_in),
  .rx_fifo_push_out(rx_fifo_push_out),
  .rx_reset_out(rx_reset_out),
  .tx_fifo_push_out(tx_fifo_push_out),
  .tx_reset_out(tx_reset_out),
  .rx_char_in(rx_char_in),
  .rx_shift_out(rx_shift_out)
);

/* verification/ssa_cpu_model.sv */
`timescale 1ns/100ps
module ssa_cpu_model (
  // Processor bus
  input logic clk_in,
  input logic [7:0] rdata_in,
  output logic cs_n_out,
  output logic rs_out,
  output logic rw_out,
  output logic [7:0] wdata_out
);
  initial {cs_n_out, rs_out, rw_out, wdata_out} = 11'h500;
  task acc(input logic r, input logic w, input logic [7:0] d, output logic [7:0] q);
    @(negedge clk_in);
    {cs_n_out, rs_out, rw_out, wdata_out} = {1'h0, r, w, d};
    @(negedge clk_in);
    {cs_n_out, wdata_out} = {1'h1, ~d};
    q = rdata_in;
  endtask
  task start_tx(input logic [7:0] pc, input logic [7:0] d, output logic [7:0] q);
    acc(1'h0, 1'h0, pc, q);
    acc(1'h1, 1'h0, d, q);
  endtask
endmodule // ssa_cpu_model

/* verification/ssa_regs_tb.sv */
`timescale 1ns/100ps
module ssa_regs_tb;
  logic clk_in = 1'h0;
  logic rst_in = 1'h1;
  logic chip_select_n_in, register_select_line_in, read_not_write_in, data_oe_out, rx_reset_out, tx_reset_out;
  logic rx_fifo_push_out, rx_fifo_pop_out, tx_fifo_push_out;
  logic [7:0] data_in, data_out, rx_fifo_wdata_out, rx_shift_out, tx_fifo_wdata_out, q;
  logic [7:0] primary_control_out, secondary_control_out, sync_pattern_out, rx_char_in = 8'h00;
  logic [7:0] rx_fifo_data_in = 8'h3C;
  logic [3:0] tertiary_control_out;
  logic rx_char_valid_in = 1'h0, rx_sync_char_in = 1'h0, rx_shift_bit_in = 1'h0, rx_parity_err_in = 1'h0;
  logic dcd_event_in = 1'h0, rx_fifo_avail_in = 1'h1, rx_overrun_in = 1'h0, tx_fifo_space_in = 1'h1;
  logic tx_underflow_in = 1'h0, cts_event_in = 1'h0, cts_level_in = 1'h0;
  int miscompares = 0, checks_done = 0, cyc = 0;
  always #10 clk_in = ~clk_in;
  ssa_regs ssa_regs_i (.*);
  ssa_cpu_model ssa_cpu_model_i (.clk_in(clk_in), .rdata_in(data_out), .cs_n_out(chip_select_n_in),
    .rs_out(register_select_line_in), .rw_out(read_not_write_in), .wdata_out(data_in));
  task chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checks_done++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task conclude;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task acc(input logic r, input logic w, input logic [7:0] d);
    ssa_cpu_model_i.acc(r, w, d, q);
  endtask
  task rx(input logic s, input logic [7:0] c, input logic e);
    @(negedge clk_in);
    {rx_char_valid_in, rx_sync_char_in, rx_char_in} = {1'h1, s, c};
    @(negedge clk_in);
    rx_char_valid_in = 1'h0;
    chk("rx push", {7'h00, rx_fifo_push_out}, {7'h00, e});
    if (e) chk("rx data", rx_fifo_wdata_out, c);
  endtask
  // Flags and shifter while held
  task t_held;
    chk("rx shift", rx_shift_out, 8'hFF);
    @(negedge clk_in);
    {rx_parity_err_in, dcd_event_in, rx_overrun_in, tx_underflow_in, cts_event_in} = 5'h1F;
    @(negedge clk_in);
    {rx_parity_err_in, dcd_event_in, rx_overrun_in, tx_underflow_in, cts_event_in} = 5'h00;
    acc(1'h0, 1'h1, 8'h00);
    chk("status", q, 8'h00);
    chk("status oe", {7'h00, data_oe_out}, 8'h01);
    acc(1'h0, 1'h0, 8'h03);
    acc(1'h1, 1'h0, 8'h96);
    chk("secondary", secondary_control_out, 8'h96);
    acc(1'h0, 1'h0, 8'h43);
    acc(1'h1, 1'h0, 8'hF6);
    chk("tertiary", {4'h0, tertiary_control_out}, 8'h06);
  endtask
  // Writes, held and released transmitter
  task t_tx;
    acc(1'h0, 1'h0, 8'h83);
    chk("primary", primary_control_out, 8'h83);
    acc(1'h1, 1'h0, 8'h7E);
    chk("sync", sync_pattern_out, 8'h7E);
    acc(1'h0, 1'h0, 8'hC3);
    acc(1'h1, 1'h0, 8'h5A);
    chk("tx held", {7'h00, tx_fifo_push_out}, 8'h00);
    ssa_cpu_model_i.start_tx(8'hC0, 8'hA5, q);
    chk("tx push", {7'h00, tx_fifo_push_out}, 8'h01);
    chk("tx data", tx_fifo_wdata_out, 8'hA5);
    chk("resets", {6'h00, rx_reset_out, tx_reset_out}, 8'h00);
    acc(1'h1, 1'h1, 8'h00);
    chk("rx fifo", q, 8'h3C);
    chk("rx pop", {7'h00, rx_fifo_pop_out}, 8'h01);
    acc(1'h0, 1'h1, 8'h00);
    chk("status run", q, 8'h03);
  endtask
  // Stripping on and off
  task t_strip;
    acc(1'h0, 1'h0, 8'hC4);
    rx(1'h0, 8'h7E, 1'h0);
    rx(1'h0, 8'h31, 1'h1);
    rx(1'h1, 8'h16, 1'h0);
    acc(1'h0, 1'h0, 8'hC0);
    rx(1'h0, 8'h7E, 1'h1);
    chk("rx shift run", rx_shift_out, 8'hF0);
    @(negedge clk_in);
    {rx_parity_err_in, tx_underflow_in} = 2'h3;
    @(negedge clk_in);
    {rx_parity_err_in, tx_underflow_in} = 2'h0;
    acc(1'h0, 1'h1, 8'h00);
    chk("status err", q, 8'h53);
    acc(1'h0, 1'h0, 8'hC3);
    acc(1'h0, 1'h1, 8'h00);
    chk("status held", q, 8'h00);
    chk("rx shift held", rx_shift_out, 8'hFF);
    chk("resets held", {6'h00, rx_reset_out, tx_reset_out}, 8'h03);
  endtask
  initial begin
    repeat (5) @(negedge clk_in);
    rst_in = 1'h0;
    t_held();
    t_tx();
    t_strip();
    conclude();
  end
  always @(posedge clk_in) if (++cyc == 3000) begin
    miscompares++;
    conclude();
  end
endmodule // ssa_regs_tb
